// ---- shared/pfvs_map.svh ----
// What this block does
// - initiate bit 16 write with an unchanged frequency code starts voltage change
// - pending set until voltage code reaches regulator
// - frequency codes applied as written; 200 MHz step limit left to software
// - 20-bit timeout field bits 51..32, 5 ns tick
// - initiate bit write with a new frequency code starts frequency change
// - pending set until new frequency in effect
// - both cores share one clock and voltage plane
`ifndef PFVS_MAP_SVH
`define PFVS_MAP_SVH
`define PFVS_CTL_ADDR 32'hc0010041
`define PFVS_STS_ADDR 32'hc0010042
`define PFVS_FREQ_LSB 0
`define PFVS_FREQ_MSB 5
`define PFVS_VOLT_LSB 8
`define PFVS_VOLT_MSB 13
`define PFVS_INIT_BIT 16
`define PFVS_PEND_BIT 31
`define PFVS_TO_LSB 32
`define PFVS_TO_MSB 51
`define PFVS_CUR_VOLT_LSB 32
`define PFVS_CUR_VOLT_MSB 37
`define PFVS_FREQ_RESET 6'h00
`define PFVS_VOLT_RESET 6'h00
`define PFVS_CLK_NS 50
`define PFVS_TICK_NS 5
`define PFVS_TICKS_PER_CLK (`PFVS_CLK_NS / `PFVS_TICK_NS)
`define PFVS_VCO_STEP_MHZ 200
`endif

// ---- shared/pfvs_pkg.sv ----
package pfvs_pkg;
  typedef logic [5:0] pfvs_code_t;
  typedef enum logic [1:0] {
    PFVS_IDLE = 2'b00,
    PFVS_VOLT = 2'b01,
    PFVS_LOCK = 2'b10
  } pfvs_state_e;
endpackage : pfvs_pkg

// ---- shared/pfvs_lock_if.sv ----
`timescale 1ns/1ps
// start/done handshake between sequencer and lock timer
interface pfvs_lock_if;
  logic start;         // one-cycle pulse, load count
  logic [19:0] count;  // timeout in 5 ns ticks
  logic done;          // one-cycle pulse, count expired
  modport seq (output start, output count, input done);
  modport tmr (input start, input count, output done);
endinterface : pfvs_lock_if

// ---- src/pfvs_lock_timer.sv ----
`timescale 1ns/1ps
`include "pfvs_map.svh"
// counts down stop-grant timeout; ten 5 ns ticks elapse per 50 ns clock
module pfvs_lock_timer (
  input wire logic CLK,
  input wire logic RESET,
  pfvs_lock_if.tmr lk
);
  typedef struct packed {
    logic [20:0] rem;  // ticks left, one bit of headroom
    logic busy;
    logic done;
  } pfvs_tmr_s;
  pfvs_tmr_s r;
  pfvs_tmr_s next_r;

  assign lk.done = r.done;

  // load on start, subtract ticks each clock, pulse done once
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    if (lk.start) begin
      next_r.rem = {1'b0, lk.count};
      next_r.busy = 1'b1;
    end else if (r.busy) begin
      if (r.rem <= 21'(`PFVS_TICKS_PER_CLK)) begin
        next_r.rem = 21'h000000;
        next_r.busy = 1'b0;
        next_r.done = 1'b1;
      end else begin
        next_r.rem = r.rem - 21'(`PFVS_TICKS_PER_CLK);
      end
    end
  end

  // registered state
  always_ff @(posedge CLK) begin
    if (RESET) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  // done ends the run; it never overlaps a live count
  a_done_ends_busy: assert property (@(posedge CLK)
    disable iff (RESET)
    r.done |-> !r.busy)
    else $error("done while busy");
  // a start loads the whole count with the headroom bit clear
  a_start_loads: assert property (@(posedge CLK)
    disable iff (RESET)
    lk.start |=> (r.busy && r.rem == {1'b0, $past(lk.count)}))
    else $error("timeout count not loaded");
  // ten 5 ns ticks leave the count on every clock of the run but the last
  a_tick_step: assert property (@(posedge CLK)
    disable iff (RESET)
    (r.busy && !lk.start && r.rem > 21'(`PFVS_TICKS_PER_CLK)) |=>
      (r.rem == $past(r.rem) - 21'(`PFVS_TICKS_PER_CLK)))
    else $error("timeout count stepped wrongly");
  // the last partial tick ends the run with a done pulse
  a_done_on_end: assert property (@(posedge CLK)
    disable iff (RESET)
    (r.busy && !lk.start && r.rem <= 21'(`PFVS_TICKS_PER_CLK)) |=>
      (r.done && !r.busy))
    else $error("timeout run did not end");
endmodule : pfvs_lock_timer

// ---- src/pfvs_sequencer.sv ----
`timescale 1ns/1ps
`include "pfvs_map.svh"
// performance-state register pair; drives the shared voltage code and
// frequency code for both cores, one plane for the whole die
module pfvs_sequencer (
  input wire logic CLK,
  input wire logic RESET,
  input wire logic REG_WR,          // write strobe, one cycle
  input wire logic REG_RD,          // read strobe, one cycle
  input wire logic [31:0] REG_ADDR, // register address
  input wire logic [63:0] REG_WDATA,
  output logic [63:0] REG_RDATA,    // registered read data
  output logic REG_RVALID,          // read data valid pulse
  output logic [5:0] VOLTAGE_CODE,  // to external regulator
  output logic [5:0] FREQUENCY_CODE // to core clock generator
);
  typedef struct packed {
    pfvs_pkg::pfvs_state_e st;
    pfvs_pkg::pfvs_code_t target_voltage_code;
    pfvs_pkg::pfvs_code_t target_frequency_code;
    logic [19:0] stop_grant_timeout_count;
    pfvs_pkg::pfvs_code_t current_voltage_code;
    pfvs_pkg::pfvs_code_t current_frequency_code;
    logic change_pending_flag;
    logic lock_start;
    logic [63:0] rdata;
    logic rvalid;
  } pfvs_seq_s;
  pfvs_seq_s r;
  pfvs_seq_s next_r;

  pfvs_lock_if lk ();

  // lock timer covers pll settling during frequency change
  pfvs_lock_timer u_timer (
    .CLK(CLK),
    .RESET(RESET),
    .lk(lk)
  );

  // the timer reads the count stored by the initiating write; later
  // writes are refused while pending, so the count cannot move under it
  assign lk.start = r.lock_start;
  assign lk.count = r.stop_grant_timeout_count;
  assign REG_RDATA = r.rdata;
  assign REG_RVALID = r.rvalid;
  // single output pair feeds both cores
  assign VOLTAGE_CODE = r.current_voltage_code;
  assign FREQUENCY_CODE = r.current_frequency_code;

  // address decode is exact; no mirrors at neighbouring addresses
  logic ctl_wr;  // write to control register
  logic init_req;  // initiate bit seen in that write
  assign ctl_wr = REG_WR && (REG_ADDR == `PFVS_CTL_ADDR);
  assign init_req = ctl_wr && REG_WDATA[`PFVS_INIT_BIT];

  // next-state logic: register writes, reads and the change sequence
  always_comb begin
    next_r = r;
    next_r.lock_start = 1'b0;
    next_r.rvalid = 1'b0;
    // fields are written only while pending is clear so a pending change is undisturbed
    if (ctl_wr && !r.change_pending_flag) begin
      next_r.target_frequency_code =
        REG_WDATA[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB];
      next_r.target_voltage_code = REG_WDATA[`PFVS_VOLT_MSB:`PFVS_VOLT_LSB];
      next_r.stop_grant_timeout_count =
        REG_WDATA[`PFVS_TO_MSB:`PFVS_TO_LSB];
    end
    unique case (r.st)
      pfvs_pkg::PFVS_IDLE: begin
        if (init_req) begin
          next_r.change_pending_flag = 1'b1;
          // a new frequency code takes the lock path; else voltage only
          if (REG_WDATA[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB]
              != r.current_frequency_code) begin
            next_r.st = pfvs_pkg::PFVS_LOCK;
            // the 200 MHz oscillator step limit is left to software: a
            // code is applied as written, so a wide jump would still
            // reach the clock generator in one step
            next_r.lock_start = 1'b1;
            next_r.current_frequency_code =
              REG_WDATA[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB];
          end else begin
            next_r.st = pfvs_pkg::PFVS_VOLT;
          end
        end
      end
      pfvs_pkg::PFVS_VOLT: begin
        // present voltage code and release pending on the same edge
        next_r.current_voltage_code = r.target_voltage_code;
        next_r.change_pending_flag = 1'b0;
        next_r.st = pfvs_pkg::PFVS_IDLE;
      end
      pfvs_pkg::PFVS_LOCK: begin
        // frequency counted in effect only after the lock timeout
        if (lk.done) begin
          next_r.change_pending_flag = 1'b0;
          next_r.st = pfvs_pkg::PFVS_IDLE;
        end
      end
      default: begin
        // code 2'b11 is illegal; recover to idle
        next_r.st = pfvs_pkg::PFVS_IDLE;
        next_r.change_pending_flag = 1'b0;
      end
    endcase
    // read mux; unmapped addresses read as zero
    // the answer lands one edge later and stands until the next read
    if (REG_RD) begin
      next_r.rvalid = 1'b1;
      next_r.rdata = 64'h0000000000000000;
      if (REG_ADDR == `PFVS_CTL_ADDR) begin
        next_r.rdata[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB] =
          r.target_frequency_code;
        next_r.rdata[`PFVS_VOLT_MSB:`PFVS_VOLT_LSB] = r.target_voltage_code;
        next_r.rdata[`PFVS_TO_MSB:`PFVS_TO_LSB] =
          r.stop_grant_timeout_count;
      end else if (REG_ADDR == `PFVS_STS_ADDR) begin
        next_r.rdata[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB] =
          r.current_frequency_code;
        next_r.rdata[`PFVS_CUR_VOLT_MSB:`PFVS_CUR_VOLT_LSB] =
          r.current_voltage_code;
        next_r.rdata[`PFVS_PEND_BIT] = r.change_pending_flag;
      end
    end
  end

  // registered state; powers up at lowest codes
  always_ff @(posedge CLK) begin
    if (RESET) begin
      r <= '0;
      r.current_voltage_code <= `PFVS_VOLT_RESET;
      r.current_frequency_code <= `PFVS_FREQ_RESET;
    end else begin
      r <= next_r;
    end
  end

  // checks on the change sequence and register reads; each sleeps while reset is high
  // an initiating write from idle raises pending on the next edge
  a_init_sets_pend: assert property (@(posedge CLK)
    disable iff (RESET)
    (init_req && !r.change_pending_flag) |=> r.change_pending_flag)
    else $error("initiate did not set pending");
  // the voltage step presents the stored code as pending drops
  a_volt_clears_pend: assert property (@(posedge CLK)
    disable iff (RESET)
    (r.st == pfvs_pkg::PFVS_VOLT) |=>
      (!r.change_pending_flag && VOLTAGE_CODE == $past(r.target_voltage_code)))
    else $error("voltage not presented on pending clear");
  // a voltage-only change is over two edges after its write
  a_volt_path_two: assert property (@(posedge CLK)
    disable iff (RESET)
    (init_req && r.st == pfvs_pkg::PFVS_IDLE &&
     REG_WDATA[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB] == r.current_frequency_code)
    |=> ##1 !r.change_pending_flag)
    else $error("voltage change took wrong time");
  // a new frequency code starts the lock timer at once
  a_freq_starts_lock: assert property (@(posedge CLK)
    disable iff (RESET)
    (init_req && r.st == pfvs_pkg::PFVS_IDLE &&
     REG_WDATA[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB] != r.current_frequency_code)
    |=> (r.lock_start && r.st == pfvs_pkg::PFVS_LOCK))
    else $error("frequency change did not start timer");
  // and reaches the clock generator on that same edge
  a_freq_applied: assert property (@(posedge CLK)
    disable iff (RESET)
    (init_req && r.st == pfvs_pkg::PFVS_IDLE &&
     REG_WDATA[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB] != r.current_frequency_code)
    |=> FREQUENCY_CODE == $past(REG_WDATA[`PFVS_FREQ_MSB:`PFVS_FREQ_LSB]))
    else $error("frequency code not applied");
  // the codes move only at the steps that own them
  a_volt_moves_late: assert property (@(posedge CLK)
    disable iff (RESET)
    $changed(VOLTAGE_CODE) |-> $past(r.st) == pfvs_pkg::PFVS_VOLT)
    else $error("voltage code moved outside voltage step");
  a_freq_moves_late: assert property (@(posedge CLK)
    disable iff (RESET)
    $changed(FREQUENCY_CODE) |->
      $past(init_req && r.st == pfvs_pkg::PFVS_IDLE))
    else $error("frequency code moved without initiate");
  // pending stands through the lock wait and drops right after it
  a_lock_holds_pend: assert property (@(posedge CLK)
    disable iff (RESET)
    (r.st == pfvs_pkg::PFVS_LOCK && !lk.done) |=> r.change_pending_flag)
    else $error("pending dropped before lock");
  a_done_clears: assert property (@(posedge CLK)
    disable iff (RESET)
    (r.st == pfvs_pkg::PFVS_LOCK && lk.done) |=> !r.change_pending_flag)
    else $error("pending stuck after lock");
  // a write while pending changes no field and starts nothing
  a_busy_ignores: assert property (@(posedge CLK)
    disable iff (RESET)
    (ctl_wr && r.change_pending_flag) |=>
      ($stable(r.target_voltage_code) && $stable(r.target_frequency_code)))
    else $error("write changed fields while pending");
  a_busy_no_start: assert property (@(posedge CLK)
    disable iff (RESET)
    (ctl_wr && r.change_pending_flag) |=>
      (!r.lock_start && $stable(r.stop_grant_timeout_count)))
    else $error("write while pending disturbed the timer");
  // an idle write stores the timeout field for the lock timer
  a_count_latched: assert property (@(posedge CLK)
    disable iff (RESET)
    (ctl_wr && !r.change_pending_flag) |=>
      (r.stop_grant_timeout_count ==
       $past(REG_WDATA[`PFVS_TO_MSB:`PFVS_TO_LSB])))
    else $error("timeout field not stored");
  // a read answers one edge later; polling relies on that rhythm
  a_read_pulse: assert property (@(posedge CLK)
    disable iff (RESET)
    REG_RD |=> REG_RVALID ##1 (!REG_RVALID || $past(REG_RD)))
    else $error("read valid not a pulse");
  // read data stand until the next read
  a_rdata_stands: assert property (@(posedge CLK)
    disable iff (RESET)
    !REG_RD |=> $stable(REG_RDATA))
    else $error("read data moved without a read");
  // status bit 31 shows the pending flag of the sampling edge
  a_pend_reads_back: assert property (@(posedge CLK)
    disable iff (RESET)
    (REG_RD && REG_ADDR == `PFVS_STS_ADDR) |=>
      (REG_RDATA[`PFVS_PEND_BIT] == $past(r.change_pending_flag)))
    else $error("status read lost the pending flag");
endmodule : pfvs_sequencer

// ---- dv/pfvs_vreg_model.sv ----
`timescale 1ns/1ps
// behavioural regulator: the rail follows a new voltage code once the code has
// differed from the rail for SETTLE clocks; the count does not restart when the code moves
module pfvs_vreg_model #(
  parameter int SETTLE = 3 // settle delay in clocks, 0 answers promptly
) (
  input wire logic CLK,
  input wire logic [5:0] VOLTAGE_CODE,
  output logic [5:0] rail_code
);
  int cnt = 0; // clocks the requested code has been waiting
  initial rail_code = 6'h00;
  // rail update after the settle delay
  always @(posedge CLK) begin
    if (VOLTAGE_CODE !== rail_code && cnt < SETTLE) begin
      cnt <= cnt + 1;
    end else begin
      rail_code <= VOLTAGE_CODE;
      cnt <= 0;
    end
  end
endmodule : pfvs_vreg_model

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
`include "pfvs_map.svh"
module tb_top;
  logic CLK = 1'b0, RESET = 1'b1, REG_WR = 1'b0, REG_RD = 1'b0;
  logic [31:0] REG_ADDR = 32'h0;
  logic [63:0] REG_WDATA = 64'h0, REG_RDATA, rd_val;
  logic REG_RVALID;
  logic [5:0] VOLTAGE_CODE, FREQUENCY_CODE, rail_code, f_tgt;
  int fails = 0, cmp_count = 0, cyc = 0, t0 = 0;
  // 50 ns clock and a free cycle count for lock timing
  always #25 CLK = ~CLK;
  always @(posedge CLK) cyc <= cyc + 1;
  pfvs_sequencer i_pfvs_sequencer (.CLK(CLK), .RESET(RESET),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_ADDR(REG_ADDR),
    .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID),
    .VOLTAGE_CODE(VOLTAGE_CODE), .FREQUENCY_CODE(FREQUENCY_CODE));
  pfvs_vreg_model #(.SETTLE(3)) i_pfvs_vreg_model (.CLK(CLK),
    .VOLTAGE_CODE(VOLTAGE_CODE), .rail_code(rail_code));
  task close_out;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : close_out
  task chk(input string what, input logic [63:0] exp, got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  // control word: timeout, initiate bit, voltage and frequency codes
  function logic [63:0] ctl(input logic [19:0] to, input logic go,
                            input logic [5:0] v, f);
    return {12'h0, to, 15'h0, go, 2'h0, v, 2'h0, f};
  endfunction : ctl
  // status word with pending clear
  function logic [63:0] sts(input logic [5:0] v, f);
    return {26'h0, v, 26'h0, f};
  endfunction : sts
  // one-cycle write strobe, inputs move 1 ns after the edge
  task wr(input logic [31:0] a, input logic [63:0] d);
    @(posedge CLK);
    #1;
    REG_WR = 1'b1;
    REG_ADDR = a;
    REG_WDATA = d;
    @(posedge CLK);
    #1;
    REG_WR = 1'b0;
  endtask : wr
  // read strobe, then a bounded wait for the valid pulse
  task rd(input logic [31:0] a);
    @(posedge CLK);
    #1;
    REG_RD = 1'b1;
    REG_ADDR = a;
    @(posedge CLK);
    #1;
    REG_RD = 1'b0;
    for (int i = 0; i < 4 && REG_RVALID !== 1'b1; i++) begin
      @(posedge CLK);
      #1;
    end
    chk("read valid", 64'h1, 64'(REG_RVALID));
    rd_val = REG_RDATA;
  endtask : rd
  // software polls pending before each next step, bounded
  task poll;
    for (int i = 0; i < 3000; i++) begin
      rd(`PFVS_STS_ADDR);
      if (rd_val[31] === 1'b0) break;
    end
    chk("pending clear", 64'h0, 64'(rd_val[31]));
  endtask : poll
  // agent keeps both cores at the faster of two requested codes
  function logic [5:0] pick(input logic [5:0] a, b);
    return (a > b) ? a : b;
  endfunction : pick
  initial begin
    repeat (16) @(posedge CLK);
    #1;
    RESET = 1'b0;
    rd(`PFVS_STS_ADDR);
    chk("status after reset", sts(6'h00, 6'h00), rd_val);
    rd(32'h0);
    chk("unmapped read", 64'h0, rd_val);
    $display("test reset done");
    // voltage step keeps the frequency code
    wr(`PFVS_CTL_ADDR, ctl(20'h0, 1'b1, 6'h12, 6'h00));
    poll;
    chk("voltage code", 64'h12, 64'(VOLTAGE_CODE));
    repeat (5) @(posedge CLK);
    #1;
    chk("rail code", 64'h12, 64'(rail_code));
    $display("test voltage done");
    // frequency step with a 2 us lock count, then a write while pending
    t0 = cyc;
    wr(`PFVS_CTL_ADDR, ctl(20'd400, 1'b1, 6'h12, 6'h02));
    rd(`PFVS_STS_ADDR);
    chk("pending set", 64'h1, 64'(rd_val[31]));
    wr(`PFVS_CTL_ADDR, ctl(20'd400, 1'b1, 6'h12, 6'h04));
    poll;
    chk("lock wait", 64'h1, 64'(cyc - t0 >= 40));
    chk("lock end", 64'h1, 64'(cyc - t0 <= 50));
    chk("frequency code", 64'h02, 64'(FREQUENCY_CODE));
    rd(`PFVS_STS_ADDR);
    chk("status codes", sts(6'h12, 6'h02), rd_val);
    rd(`PFVS_CTL_ADDR);
    chk("control fields", ctl(20'd400, 1'b0, 6'h12, 6'h02), rd_val);
    $display("test frequency done");
    // no initiate bit, and a status write, must leave codes alone
    wr(`PFVS_CTL_ADDR, ctl(20'h0, 1'b0, 6'h20, 6'h00));
    wr(`PFVS_STS_ADDR, 64'hffffffffffffffff);
    repeat (4) @(posedge CLK);
    #1;
    chk("voltage hold", 64'h12, 64'(VOLTAGE_CODE));
    rd(`PFVS_STS_ADDR);
    chk("status hold", sts(6'h12, 6'h02), rd_val);
    $display("test refuse done");
    // full change: voltage up, two frequency steps of at most 200 MHz
    // of oscillator, relief wait between them, then target voltage
    wr(`PFVS_CTL_ADDR, ctl(20'h0, 1'b1, 6'h10, 6'h02));
    poll;
    chk("phase 1 voltage", 64'h10, 64'(VOLTAGE_CODE));
    wr(`PFVS_CTL_ADDR, ctl(20'd20, 1'b1, 6'h10, 6'h0c));
    poll;
    repeat (4) @(posedge CLK);
    f_tgt = pick(6'h0e, 6'h0a);
    wr(`PFVS_CTL_ADDR, ctl(20'd20, 1'b1, 6'h10, f_tgt));
    poll;
    chk("phase 2 frequency", 64'h0e, 64'(FREQUENCY_CODE));
    // one core asks lower; the shared code stays at the faster one
    f_tgt = pick(6'h02, 6'h0e);
    wr(`PFVS_CTL_ADDR, ctl(20'h0, 1'b1, 6'h0c, f_tgt));
    poll;
    rd(`PFVS_STS_ADDR);
    chk("phase 3 status", sts(6'h0c, 6'h0e), rd_val);
    $display("test pstate done");
    close_out;
  end
  // watchdog at 20000 clocks, far beyond the hundred or so clocks the tests need
  initial begin
    #(50 * 20000);
    fails++;
    close_out;
  end
endmodule : tb_top
